// ### hdl/adlw_consts.svh
// timing counts and field widths for the axis converter loader and watchdogs
`ifndef ADLW_CONSTS_SVH
`define ADLW_CONSTS_SVH
`define ADLW_CLK_NS        10
`define ADLW_WORD_W        12
`define ADLW_CHAN_N        5
`define ADLW_CHAN_W        3
`define ADLW_BIT_CNT_W     4
`define ADLW_SEL_CNT_W     3
`define ADLW_FIFO_DEPTH    8
`define ADLW_WD_MOTION_MS  5
`define ADLW_WD_MAIN_MS    20
`define ADLW_WD_MOTION_CYC ((`ADLW_WD_MOTION_MS * 1000000) / `ADLW_CLK_NS)
`define ADLW_WD_MAIN_CYC   ((`ADLW_WD_MAIN_MS * 1000000) / `ADLW_CLK_NS)
`define ADLW_SETTLE_CYC    2'h3
`define ADLW_WD_CNT_W      22
`define ADLW_IN_BITS       4
`define ADLW_IN_OVR        2'h0
`define ADLW_IN_FEED       2'h1
`define ADLW_IN_BATT       2'h2
`define ADLW_IN_TEMP       2'h3
`endif

// ### hdl/adlw_pkg.sv
// types shared by the axis converter loader
package adlw_pkg;
    typedef enum logic [1:0] {
        ADLW_IDLE  = 2'b00,
        ADLW_LOAD  = 2'b01,
        ADLW_SETTLE = 2'b10
    } adlw_state_e;
    typedef logic [11:0] adlw_word_t;
endpackage : adlw_pkg

// ### hdl/adlw_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module adlw_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : adlw_fifo

// ### hdl/adlw_top.sv
// serial-to-parallel converter loader, sample-hold routing, supervision return, watchdogs
`timescale 1ns/10ps
`include "adlw_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - Each value on the serial output line becomes a 12-bit converter word.
// - Successive results go to five hold channels: X, Y, Z, fourth axis, spindle.
// - Override and feed comparison results return on the serial input line.
// - Low battery and over-temperature are returned as bits on the serial input line.
// - A watchdog not retriggered within its interval raises emergency stop.
module adlw_top (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        serial_clk,
    input  wire logic        serial_out_line,
    input  wire logic        word_sync,
    input  wire logic [2:0]  in_sel,
    input  wire logic        override_above,
    input  wire logic        feed_above,
    input  wire logic        battery_low,
    input  wire logic        temp_high,
    input  wire logic        motion_wd_kick,
    input  wire logic        main_wd_kick,
    output logic [11:0]      dac_word_q,
    output logic [4:0]       hold_strobe_q,
    output logic [2:0]       hold_chan_q,
    output logic             serial_in_line_q,
    output logic             estop_q,
    output logic             overrun_q
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, clean_q;
    assign pin_raw = {serial_clk, serial_out_line, word_sync, in_sel, override_above,
                      feed_above, battery_low, temp_high, motion_wd_kick ^ 1'b0};
    logic main_s1_q, main_s2_q, main_s3_q, main_clean_q;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q[gi]    <= 1'b0;
                    s2_q[gi]    <= 1'b0;
                    s3_q[gi]    <= 1'b0;
                    clean_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) clean_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_s1_q    <= 1'b0;
            main_s2_q    <= 1'b0;
            main_s3_q    <= 1'b0;
            main_clean_q <= 1'b0;
        end else begin
            main_s1_q <= main_wd_kick;
            main_s2_q <= main_s1_q;
            main_s3_q <= main_s2_q;
            if (main_s2_q == main_s3_q) main_clean_q <= main_s3_q;
        end
    end
    wire       sclk_c   = clean_q[10];
    wire       sdat_c   = clean_q[9];
    wire       sync_c   = clean_q[8];
    wire [2:0] sel_c    = clean_q[7:5];
    wire [3:0] sup_c    = clean_q[4:1];
    wire       mkick_c  = clean_q[0];
    logic      sclk_d1_q, sync_d1_q, mkick_d1_q, kmain_d1_q;
    wire       sclk_rise = sclk_c && !sclk_d1_q;
    wire       sync_rise = sync_c && !sync_d1_q;
    wire       mkick_ev  = mkick_c != mkick_d1_q;
    wire       kmain_ev  = main_clean_q != kmain_d1_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d1_q  <= 1'b0;
            sync_d1_q  <= 1'b0;
            mkick_d1_q <= 1'b0;
            kmain_d1_q <= 1'b0;
        end else begin
            sclk_d1_q  <= sclk_c;
            sync_d1_q  <= sync_c;
            mkick_d1_q <= mkick_c;
            kmain_d1_q <= main_clean_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // deserialiser: msb first, 12 data bits; word_sync restarts the frame and channel count
    logic [11:0] shift_q;
    logic [3:0]  bit_cnt_q;
    logic [2:0]  chan_cnt_q;
    wire         word_done = sclk_rise && (bit_cnt_q == 4'(`ADLW_WORD_W - 1));
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q    <= 12'h000;
            bit_cnt_q  <= 4'h0;
            chan_cnt_q <= 3'h0;
        end else if (sync_rise) begin
            bit_cnt_q  <= 4'h0;
            chan_cnt_q <= 3'h0;
        end else if (sclk_rise) begin
            shift_q   <= {shift_q[10:0], sdat_c};
            bit_cnt_q <= word_done ? 4'h0 : bit_cnt_q + 4'h1;
            if (word_done) begin
                chan_cnt_q <= (chan_cnt_q == 3'(`ADLW_CHAN_N - 1)) ? 3'h0 : chan_cnt_q + 3'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // fifo decouples word arrival from the converter load/settle sequence
    logic [14:0] f_out;
    logic        f_valid, f_ready, f_in_ready;
    adlw_fifo #(.WIDTH(15), .DEPTH(`ADLW_FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .in_data  ({chan_cnt_q, {shift_q[10:0], sdat_c}}),
        .in_valid (word_done),
        .in_ready (f_in_ready),
        .out_data (f_out),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );
    ////////////////////////////////////////////////////////////////////////////
    // converter sequence: load word, wait settle, then pulse exactly one hold strobe
    localparam logic [1:0] SETTLE_CYC = `ADLW_SETTLE_CYC;
    adlw_pkg::adlw_state_e st_q;
    logic [1:0] settle_q;
    assign f_ready = (st_q == adlw_pkg::ADLW_IDLE);
    function automatic logic [4:0] chan_onehot(input logic [2:0] c);
        chan_onehot = (c < 3'(`ADLW_CHAN_N)) ? 5'(5'h01 << c) : 5'h00;
    endfunction : chan_onehot
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q          <= adlw_pkg::ADLW_IDLE;
            dac_word_q    <= 12'h000;
            hold_chan_q   <= 3'h0;
            hold_strobe_q <= 5'h00;
            settle_q      <= 2'h0;
            overrun_q     <= 1'b0;
        end else begin
            hold_strobe_q <= 5'h00;
            if (word_done && !f_in_ready) overrun_q <= 1'b1;
            case (st_q)
                adlw_pkg::ADLW_IDLE: begin
                    if (f_valid) begin
                        dac_word_q  <= f_out[11:0];
                        hold_chan_q <= f_out[14:12];
                        settle_q    <= SETTLE_CYC;
                        st_q        <= adlw_pkg::ADLW_SETTLE;
                    end
                end
                adlw_pkg::ADLW_SETTLE: begin
                    if (settle_q == 2'h0) begin
                        hold_strobe_q <= chan_onehot(hold_chan_q);
                        st_q          <= adlw_pkg::ADLW_IDLE;
                    end else begin
                        settle_q <= settle_q - 2'h1;
                    end
                end
                default: st_q <= adlw_pkg::ADLW_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // supervision return: in_sel picks the bit driven onto the input line
    wire sel_ok = (sel_c < 3'(`ADLW_IN_BITS));
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) serial_in_line_q <= 1'b0;
        else serial_in_line_q <= sel_ok ? sup_c[3 - sel_c[1:0]] : 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // watchdogs: any edge of a kick input retriggers; expiry latches estop until reset
    logic [21:0] wd_m_q, wd_p_q;
    // counters park at their limit so a missed kick can never wrap back to a quiet state
    wire         wd_m_exp = (wd_m_q == 22'(`ADLW_WD_MOTION_CYC));
    wire         wd_p_exp = (wd_p_q == 22'(`ADLW_WD_MAIN_CYC));
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_m_q  <= 22'h000000;
            wd_p_q  <= 22'h000000;
            estop_q <= 1'b0;
        end else begin
            wd_m_q <= mkick_ev ? 22'h000000 : wd_m_exp ? wd_m_q : wd_m_q + 22'h1;
            wd_p_q <= kmain_ev ? 22'h000000 : wd_p_exp ? wd_p_q : wd_p_q + 22'h1;
            if (wd_m_exp || wd_p_exp) begin
                estop_q <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    wd_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wd_m_exp |=> estop_q) else $error("estop missed");
    wd_main_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wd_p_exp |=> estop_q) else $error("estop missed on main watchdog");
    estop_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        estop_q |=> estop_q) else $error("estop dropped");
    one_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $onehot0(hold_strobe_q)) else $error("multiple hold strobes");
    sequence load_s;
        st_q == adlw_pkg::ADLW_IDLE && f_valid;
    endsequence
    strobe_after_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        load_s |=> ##4 (hold_strobe_q != 5'h00)) else $error("strobe late");
    word_stable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_q == adlw_pkg::ADLW_SETTLE) |=> $stable(dac_word_q)) else $error("word moved");
    sup_path_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (sel_c == 3'h2) |=> serial_in_line_q == $past(sup_c[1])) else $error("battery bit");
    cmp_path_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (sel_c == 3'h0) |=> serial_in_line_q == $past(sup_c[3])) else $error("override bit");
    bit_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bit_cnt_q < 4'(`ADLW_WORD_W)) else $error("bit count overrun");
endmodule : adlw_top

// ### testbench/adlw_sender.sv
// serial word sender standing in for the motion processor
`timescale 1ns/10ps
module adlw_sender (
    input  wire logic sys_clk,
    output logic      serial_clk,
    output logic      serial_out_line,
    output logic      word_sync
);
    initial begin
        serial_clk      = 1'b0;
        serial_out_line = 1'b0;
        word_sync       = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold
    // bit clock stands low between frames; each phase 5 cycles to clear the input filter
    task automatic send_bits(input logic [11:0] w, input int n);
        @(posedge sys_clk);
        for (int i = 11; i > 11 - n; i--) begin
            serial_out_line <= w[i];
            hold(5);
            serial_clk <= 1'b1;
            hold(5);
            serial_clk <= 1'b0;
        end
        hold(5);
        // a released line must not keep showing the last bit
        serial_out_line <= ~serial_out_line;
    endtask : send_bits
    task automatic sync();
        @(posedge sys_clk);
        word_sync <= 1'b1;
        hold(5);
        word_sync <= 1'b0;
        hold(5);
    endtask : sync
endmodule : adlw_sender

// ### testbench/adlw_top_tb_top.sv
// self-checking bench for the converter loader, return line and watchdogs
`timescale 1ns/10ps
module adlw_top_tb_top;
    logic        sys_clk = 1'b0, rst_b = 1'b0, mk = 1'b0, nk = 1'b0;
    logic [2:0]  in_sel = 3'h0;
    logic [3:0]  sup = 4'h0;
    wire  logic  s_clk, s_dat, s_sync;
    logic [11:0] dac_word_q;
    logic [4:0]  hold_strobe_q;
    logic [2:0]  hold_chan_q;
    logic        serial_in_line_q, estop_q, overrun_q;
    int          n_fail = 0, compares = 0, cyc = 0, k;
    logic [11:0] words [6] = '{12'hFFF, 12'h800, 12'h001, 12'hA5C, 12'h000, 12'h123};
    always #5 sys_clk = ~sys_clk;
    adlw_sender sender_u (.sys_clk(sys_clk), .serial_clk(s_clk), .serial_out_line(s_dat),
                          .word_sync(s_sync));
    adlw_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(s_clk),
        .serial_out_line(s_dat), .word_sync(s_sync), .in_sel(in_sel),
        .override_above(sup[0]), .feed_above(sup[1]), .battery_low(sup[2]),
        .temp_high(sup[3]), .motion_wd_kick(mk), .main_wd_kick(nk),
        .dac_word_q(dac_word_q), .hold_strobe_q(hold_strobe_q), .hold_chan_q(hold_chan_q),
        .serial_in_line_q(serial_in_line_q), .estop_q(estop_q), .overrun_q(overrun_q));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // wait for the hold strobe, then check word, channel and the one-hot strobe
    task automatic word_check(input logic [11:0] w, input logic [2:0] ch);
        k = 0;
        // look just after each edge so the one-cycle strobe is seen while it stands
        #1;
        while (hold_strobe_q === 5'h00 && k < 60) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk(16'(k < 60), 16'h0001);
        chk(16'(dac_word_q), 16'(w));
        chk(16'(hold_chan_q), 16'(ch));
        chk(16'(hold_strobe_q), 16'(5'h01 << ch));
        @(posedge sys_clk);
        #1;
        chk(16'(hold_strobe_q), 16'h0000);
    endtask : word_check
    // watchdogs serviced well inside both intervals: toggling counts as a kick
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc % 1000 == 999) begin
            mk <= ~mk;
            nk <= ~nk;
        end
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    //////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        chk({dac_word_q, hold_strobe_q[3:0]}, 16'h0000);
        chk(16'({hold_chan_q, hold_strobe_q[4], serial_in_line_q, estop_q, overrun_q}), 16'h0000);
        sender_u.sync();
        // five channels in order, the sixth word wraps back to X
        for (int i = 0; i < 6; i++) begin
            sender_u.send_bits(words[i], 12);
            word_check(words[i], 3'(i % 5));
        end
        // a partial word is thrown away by the sync and the next word goes to X
        sender_u.send_bits(12'hFC0, 6);
        repeat (20) @(posedge sys_clk);
        #1;
        chk(16'(dac_word_q), 16'h0123);
        sender_u.sync();
        sender_u.send_bits(12'h5A3, 12);
        word_check(12'h5A3, 3'h0);
        // select codes 0 to 3 with their input alone high, then alone low; codes 4 to 7 with all inputs low, then all high
        for (int s = 0; s < 8; s++) begin
            for (int v = 0; v < 2; v++) begin
                @(posedge sys_clk);
                in_sel <= 3'(s);
                if (s < 4)
                    sup <= v ? ~(4'h1 << s) : (4'h1 << s);
                else
                    sup <= v ? 4'hF : 4'h0;
                repeat (10) @(posedge sys_clk);
                #1;
                chk(16'(serial_in_line_q), 16'((s < 4) && (v == 0)));
            end
        end
        chk(16'(estop_q), 16'h0000);
        chk(16'(overrun_q), 16'h0000);
        end_of_test();
    end
endmodule : adlw_top_tb_top
